//--- pulse_pkg.sv
// Shared constants, register map and types for the two-channel pulse unit
package pulse_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the slave port)
  // ----------------------------------------------------------------
  localparam int          AW          = 11;
  localparam logic [10:0] OFF_CTRL    = 11'h000;
  localparam logic [10:0] OFF_CYCLE   = 11'h004;
  localparam logic [10:0] OFF_WIDTH   = 11'h008;
  localparam logic [10:0] OFF_COUNT   = 11'h00c;
  localparam logic [10:0] OFF_STATUS  = 11'h010;
  localparam logic [10:0] OFF_SEGMENT = 11'h014;
  localparam logic [10:0] OFF_TABLE   = 11'h018;
  localparam logic [10:0] OFF_LOAD    = 11'h01c;
  localparam logic [10:0] CH_STRIDE   = 11'h020;
  localparam logic [10:0] OFF_RUN     = 11'h040;
  localparam logic [10:0] OFF_IMAGE   = 11'h044;
  localparam logic [10:0] RAM_BASE    = 11'h400;

  // ----------------------------------------------------------------
  // Field positions, reset values and limits
  // ----------------------------------------------------------------
  localparam int          ST_PROF_ERR  = 3;
  localparam int          ST_DELTA_ERR = 4;
  localparam int          ST_ABORT     = 5;
  localparam int          ST_OVF       = 6;
  localparam int          ST_IDLE      = 7;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [31:0] DWORD_RST    = 32'h0000_0000;
  localparam logic [15:0] MIN_CYCLE    = 16'h0002;
  localparam logic [3:0]  SEG_LAST     = 4'h7;
  localparam int          RAM_DEPTH    = 256;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_US_NS    = 1000;
  localparam int TICK_MS_NS    = 1000000;
  localparam int US_CYCLES     = TICK_US_NS / CLK_PERIOD_NS;
  localparam int MS_CYCLES     = TICK_MS_NS / CLK_PERIOD_NS;
  localparam int PRESC_W       = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic pwm_mode;
    logic multi;
    logic pwm_sync;
    logic ms_base;
    logic upd_count;
    logic upd_width;
    logic upd_cycle;
  } ctrl_s;

  typedef enum logic [2:0] {G_IDLE, G_COUNT, G_FETCH, G_PTO, G_PWM} gen_e;

  typedef struct packed {
    ctrl_s              ctrl;
    logic [15:0]        cycle;
    logic [15:0]        width;
    logic [31:0]        count;
    logic [15:0]        table_off;
    logic               prof_err;
    logic               delta_err;
    logic               abort;
    logic               ovf;
    gen_e               gst;
    logic               ms_act;
    logic               level;
    logic               high;
    logic [15:0]        phase;
    logic [15:0]        cur_cycle;
    logic signed [15:0] delta;
    logic [31:0]        remain;
    logic               pend;
    logic [15:0]        pend_cycle;
    logic [15:0]        pend_width;
    logic [31:0]        pend_count;
    logic               pend_ms;
    logic [15:0]        last_cycle;
    logic [31:0]        last_count;
    logic [7:0]         seg_num;
    logic [7:0]         seg_left;
    logic [15:0]        fptr;
    logic [3:0]         fidx;
    logic [55:0]        fbuf;
    logic [15:0]        pwm_c;
    logic [15:0]        pwm_w;
    logic [15:0]        pcnt;
    logic               out;
  } chan_s;

  typedef struct packed {
    logic [10:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_s;

endpackage

//--- tick_prescaler.sv
// Time-base prescaler: one tick per microsecond or per millisecond
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler #(
  parameter int US_CYC = 25,
  parameter int MS_CYC = 25000,
  parameter int W      = 24
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,
  input  wire logic ms_base,
  output logic      tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } pre_s;

  pre_s         st;
  pre_s         nx;
  logic [W-1:0] limit;

  always_comb begin
    nx = st;
    limit = ms_base ? W'(MS_CYC - 1) : W'(US_CYC - 1);
    nx.tick = 1'b0;
    // Restart counts its own edge, so the first tick lands one full period after a load
    if (restart) begin
      nx.cnt = W'(1);
    end else if (st.cnt >= limit) begin
      nx.cnt = '0;
      nx.tick = 1'b1;
    end else begin
      nx.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign tick = st.tick;
endmodule
`default_nettype wire

//--- profile_ram.sv
// Byte-wide profile table memory, one write port and three read ports
`timescale 1ns/1ps
`default_nettype none
module profile_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr_a,
  input  wire logic [AW-1:0] raddr_b,
  input  wire logic [AW-1:0] raddr_c,
  output logic      [7:0]    rdata_a,
  output logic      [7:0]    rdata_b,
  output logic      [7:0]    rdata_c
);
  logic [7:0] mem [DEPTH];

  // Contents are software data, so no reset is applied
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
  assign rdata_c = mem[raddr_c];
endmodule
`default_nettype wire

//--- pulse_unit_top.sv
// Two-channel pulse-train and width-modulation generator with Avalon-MM slave
// ----------------------------------------------------------------
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pulse_unit_top
  import pulse_pkg::*;
#(
  parameter int TICK_MS_CYCLES = pulse_pkg::MS_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic [10:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             PULSE_OUTPUT_ZERO,
  output logic             PULSE_OUTPUT_ONE
);
  import pulse_pkg::*;

  typedef struct packed {
    chan_s [1:0] ch;
    logic  [1:0] img;
    logic        run;
    logic        waitreq;
    logic [31:0] rdata;
  } state_s;

  state_s      st;
  state_s      nx;
  av_req_s     req;
  logic [1:0]  tick;
  logic [1:0]  restart;
  logic [1:0]  ms_sel;
  logic [7:0]  ram_rd [2];
  logic [7:0]  ram_bus;
  logic [7:0]  ram_raddr [2];
  logic        ram_we;
  logic        wr_ack;
  logic [1:0]  ld;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Start a train: cycle floor of two ticks, zero count means one pulse
  function automatic chan_s begin_train(input chan_s x, input logic [15:0] cyc,
                                        input logic [31:0] cnt, input logic ms);
    chan_s r;
    r = x;
    r.cur_cycle = (cyc < MIN_CYCLE) ? MIN_CYCLE : cyc;
    r.remain = (cnt == DWORD_RST) ? 32'h0000_0001 : cnt;
    r.high = 1'b1;
    r.level = 1'b1;
    r.phase = r.cur_cycle - (r.cur_cycle >> 1);
    r.gst = G_PTO;
    r.ms_act = ms;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gen_tick
    tick_prescaler #(
      .US_CYC(US_CYCLES),
      .MS_CYC(TICK_MS_CYCLES),
      .W     (PRESC_W)
    ) u_presc (
      .clk    (MCLK),
      .rst    (RST),
      .restart(restart[g]),
      .ms_base(ms_sel[g]),
      .tick   (tick[g])
    );
    assign ram_raddr[g] = st.ch[g].fptr[7:0];
  end

  profile_ram #(
    .DEPTH(RAM_DEPTH),
    .AW   (8)
  ) u_ram (
    .clk    (MCLK),
    .we     (ram_we),
    .waddr  (req.address[9:2]),
    .wdata  (req.writedata[7:0]),
    .raddr_a(ram_raddr[0]),
    .raddr_b(ram_raddr[1]),
    .raddr_c(req.address[9:2]),
    .rdata_a(ram_rd[0]),
    .rdata_b(ram_rd[1]),
    .rdata_c(ram_bus)
  );

  // ----------------------------------------------------------------
  // Bus and generator logic
  // ----------------------------------------------------------------
  assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                 writedata: AVS_WRITEDATA, byteenable: AVS_BYTEENABLE};
  // A write lands only at the edge where the master sees waitrequest low
  assign wr_ack = req.write && !st.waitreq;
  assign ram_we = wr_ack && req.address[10] && req.byteenable[0];

  always_comb begin
    chan_s              x;
    logic [10:0]        base;
    logic [31:0]        rv;
    logic [15:0]        nc;
    logic [15:0]        nw;
    logic [31:0]        ncnt;
    logic signed [17:0] sum;
    logic [63:0]        full;
    nx = st;
    x = '0;
    base = 11'h000;
    nc = WORD_RST;
    nw = WORD_RST;
    ncnt = DWORD_RST;
    sum = '0;
    full = '0;
    ms_sel = 2'b00;
    rv = DWORD_RST;
    restart = 2'b00;
    ld = 2'b00;
    // One cycle of waitrequest low answers each request
    nx.waitreq = !((req.read || req.write) && st.waitreq);
    if (req.address[10]) begin
      rv = {24'h000000, ram_bus};
    end else if (req.address == OFF_RUN) begin
      rv = {31'h00000000, st.run};
    end else if (req.address == OFF_IMAGE) begin
      rv = {30'h00000000, st.img};
    end
    if (wr_ack && req.address == OFF_IMAGE && req.byteenable[0]) begin
      nx.img = req.writedata[1:0];
    end
    if (wr_ack && req.address == OFF_RUN && req.byteenable[0]) begin
      nx.run = req.writedata[0];
    end
    for (int c = 0; c < 2; c++) begin
      x = st.ch[c];
      base = (c == 0) ? 11'h000 : CH_STRIDE;
      ms_sel[c] = x.ms_act;
      // Register reads
      case (req.address - base)
        OFF_CTRL:    rv = (req.address[10:6] == 5'h00) ? {24'h000000, x.ctrl} : rv;
        OFF_CYCLE:   rv = (req.address[10:6] == 5'h00) ? {16'h0000, x.cycle} : rv;
        OFF_WIDTH:   rv = (req.address[10:6] == 5'h00) ? {16'h0000, x.width} : rv;
        OFF_COUNT:   rv = (req.address[10:6] == 5'h00) ? x.count : rv;
        OFF_STATUS:  rv = (req.address[10:6] == 5'h00) ?
                          {24'h000000, x.gst == G_IDLE, x.ovf, x.abort, x.delta_err,
                           x.prof_err, 3'b000} : rv;
        OFF_SEGMENT: rv = (req.address[10:6] == 5'h00) ? {24'h000000, x.seg_num} : rv;
        OFF_TABLE:   rv = (req.address[10:6] == 5'h00) ? {16'h0000, x.table_off} : rv;
        default:     rv = rv;
      endcase
      // Register writes; clears come first so hardware sets below win
      if (wr_ack && req.address[10:6] == 5'h00 && req.address[5] == base[5]) begin
        case (req.address[4:0])
          OFF_CTRL[4:0]:   x.ctrl = ctrl_s'(8'(merge({24'h000000, x.ctrl}, req.writedata,
                                                     req.byteenable)));
          OFF_CYCLE[4:0]:  x.cycle = 16'(merge({16'h0000, x.cycle}, req.writedata,
                                               req.byteenable));
          OFF_WIDTH[4:0]:  x.width = 16'(merge({16'h0000, x.width}, req.writedata,
                                               req.byteenable));
          OFF_COUNT[4:0]:  x.count = merge(x.count, req.writedata, req.byteenable);
          OFF_TABLE[4:0]:  x.table_off = 16'(merge({16'h0000, x.table_off},
                                                   req.writedata, req.byteenable));
          OFF_STATUS[4:0]: begin
            if (req.byteenable[0]) begin
              x.prof_err = x.prof_err && !req.writedata[ST_PROF_ERR];
              x.delta_err = x.delta_err && !req.writedata[ST_DELTA_ERR];
              x.abort = x.abort && !req.writedata[ST_ABORT];
              x.ovf = x.ovf && !req.writedata[ST_OVF];
            end
          end
          OFF_LOAD[4:0]:   ld[c] = 1'b1;
          default:         x.ovf = x.ovf;
        endcase
      end
      if (wr_ack && req.address == OFF_RUN && req.writedata[0] && !st.run) begin
        x.ovf = 1'b0;
      end
      // Waveform engine
      case (x.gst)
        G_PTO: begin
          if (tick[c]) begin
            if (x.phase > 16'h0001) begin
              x.phase = x.phase - 16'h0001;
            end else if (x.high) begin
              x.high = 1'b0;
              x.level = 1'b0;
              x.phase = x.cur_cycle >> 1;
            end else if (x.remain > 32'h0000_0001) begin
              sum = 18'($signed({2'b00, x.cur_cycle})) + 18'($signed(x.delta));
              if (sum < 18'sd2 || sum > 18'sd65535) begin
                x.delta_err = 1'b1;
                x.gst = G_IDLE;
              end else begin
                x = begin_train(x, sum[15:0], x.remain - 32'h0000_0001, x.ms_act);
              end
            end else if (x.ctrl.multi && x.seg_left > 8'h01) begin
              x.seg_left = x.seg_left - 8'h01;
              x.seg_num = x.seg_num + 8'h01;
              x.fidx = 4'h0;
              x.gst = G_FETCH;
            end else if (!x.ctrl.multi && x.pend) begin
              restart[c] = (x.pend_ms != x.ms_act);
              x = begin_train(x, x.pend_cycle, x.pend_count, x.pend_ms);
              x.pend = 1'b0;
            end else begin
              x.gst = G_IDLE;
            end
          end
        end
        G_PWM: begin
          if (tick[c]) begin
            if (x.pcnt >= x.pwm_c - 16'h0001) begin
              x.pcnt = WORD_RST;
              if (x.pend) begin
                x.pwm_c = x.pend_cycle;
                x.pwm_w = x.pend_width;
                x.pend = 1'b0;
              end
            end else begin
              x.pcnt = x.pcnt + 16'h0001;
            end
          end
        end
        G_COUNT: begin
          if (ram_rd[c] == 8'h00) begin
            x.prof_err = 1'b1;
            x.gst = G_IDLE;
          end else begin
            x.seg_left = ram_rd[c];
            x.seg_num = 8'h01;
            x.fptr = x.fptr + 16'h0001;
            x.fidx = 4'h0;
            x.gst = G_FETCH;
          end
        end
        G_FETCH: begin
          full = {x.fbuf, ram_rd[c]};
          x.fbuf = full[55:0];
          x.fptr = x.fptr + 16'h0001;
          x.fidx = x.fidx + 4'h1;
          if (x.fidx == SEG_LAST + 4'h1) begin
            x = begin_train(x, full[63:48], full[31:0], x.ms_act);
            x.delta = full[47:32];
          end
        end
        default: x.gst = G_IDLE;
      endcase
      // Load command
      if (ld[c]) begin
        if (!x.ctrl.enable) begin
          if (st.ch[c].ctrl.multi && x.gst inside {G_COUNT, G_FETCH, G_PTO}) begin
            x.abort = 1'b1;
          end
          x.gst = G_IDLE;
          x.pend = 1'b0;
        end else if (x.ctrl.pwm_mode) begin
          nc = x.ctrl.upd_cycle ? x.cycle : x.pwm_c;
          nc = (nc < MIN_CYCLE) ? MIN_CYCLE : nc;
          nw = x.ctrl.upd_width ? x.width : x.pwm_w;
          if (x.gst == G_PWM && x.ctrl.pwm_sync && x.ms_act == x.ctrl.ms_base) begin
            x.pend = 1'b1;
            x.pend_cycle = nc;
            x.pend_width = nw;
          end else begin
            x.gst = G_PWM;
            x.pwm_c = nc;
            x.pwm_w = nw;
            x.pcnt = WORD_RST;
            x.pend = 1'b0;
            x.ms_act = x.ctrl.ms_base;
            restart[c] = 1'b1;
          end
        end else if (x.ctrl.multi) begin
          if (x.gst inside {G_IDLE, G_PWM}) begin
            x.gst = G_COUNT;
            x.fptr = x.table_off;
            x.ms_act = x.ctrl.ms_base;
            x.seg_num = 8'h00;
            x.level = 1'b0;
            restart[c] = 1'b1;
          end else begin
            x.ovf = 1'b1;
          end
        end else begin
          nc = x.ctrl.upd_cycle ? x.cycle : x.last_cycle;
          ncnt = x.ctrl.upd_count ? x.count : x.last_count;
          x.last_cycle = nc;
          x.last_count = ncnt;
          if (x.gst inside {G_IDLE, G_PWM}) begin
            x = begin_train(x, nc, ncnt, x.ctrl.ms_base);
            x.delta = 16'sh0000;
            x.pend = 1'b0;
            restart[c] = 1'b1;
          end else if (x.pend) begin
            x.ovf = 1'b1;
          end else begin
            x.pend = 1'b1;
            x.pend_cycle = nc;
            x.pend_count = ncnt;
            x.pend_ms = x.ctrl.ms_base;
          end
        end
      end
      if (x.gst == G_PWM) begin
        x.level = (x.pcnt < x.pwm_w);
      end
      // Generator owns the pin while active, else the image bit does
      x.out = (x.gst == G_IDLE) ? nx.img[c] : x.level;
      nx.ch[c] = x;
    end
    if (req.read && st.waitreq) begin
      nx.rdata = rv;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st <= '0;
      st.waitreq <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign AVS_READDATA = st.rdata;
  assign AVS_WAITREQUEST = st.waitreq;
  assign PULSE_OUTPUT_ZERO = st.ch[0].out;
  assign PULSE_OUTPUT_ONE = st.ch[1].out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  idle_follows_image_a: assert property (
    (st.ch[0].gst == G_IDLE && nx.ch[0].gst == G_IDLE) |=> (PULSE_OUTPUT_ZERO == st.img[0]))
    else $error("idle output does not follow image bit");
  active_owns_pin_a: assert property (
    (st.ch[1].gst == G_PTO) |-> (PULSE_OUTPUT_ONE == st.ch[1].high))
    else $error("active output not driven by generator");
  cycle_floor_a: assert property (
    (st.ch[0].gst == G_PTO) |-> (st.ch[0].cur_cycle >= MIN_CYCLE))
    else $error("train cycle below two ticks");
  zero_count_one_a: assert property (
    (ld[1] && st.ch[1].gst == G_IDLE && st.ch[1].ctrl.enable && !st.ch[1].ctrl.pwm_mode &&
     !st.ch[1].ctrl.multi && st.ch[1].ctrl.upd_count && st.ch[1].count == 32'h0000_0000)
    |=> (st.ch[1].gst == G_PTO && st.ch[1].remain == 32'h0000_0001))
    else $error("zero count did not become one pulse");
  overflow_sets_a: assert property (
    (ld[0] && st.ch[0].pend && st.ch[0].gst == G_PTO && st.ch[0].ctrl.enable &&
     !st.ch[0].ctrl.pwm_mode && !st.ch[0].ctrl.multi && !tick[0]) |=> st.ch[0].ovf)
    else $error("load into full slot did not flag overflow");
  overflow_sticky_a: assert property (
    (st.ch[0].ovf && !wr_ack) |=> st.ch[0].ovf)
    else $error("overflow flag dropped without a clear");
  user_abort_a: assert property (
    (ld[1] && !st.ch[1].ctrl.enable && st.ch[1].ctrl.multi && st.ch[1].gst == G_FETCH)
    |=> (st.ch[1].abort && st.ch[1].gst == G_IDLE))
    else $error("profile disable did not flag abort");
  empty_profile_a: assert property (
    (st.ch[1].gst == G_COUNT && ram_rd[1] == 8'h00 && !ld[1])
    |=> (st.ch[1].prof_err && st.ch[1].gst == G_IDLE) ##1
        (PULSE_OUTPUT_ONE == st.img[1]) [*2])
    else $error("empty profile not refused");
  pwm_zero_width_a: assert property (
    (st.ch[0].gst == G_PWM && st.ch[0].pwm_w == 0 && !st.ch[0].pend && !ld[0])
    |=> !PULSE_OUTPUT_ZERO)
    else $error("zero width PWM drove output high");
endmodule
`default_nettype wire

//--- pulse_sink.sv
// Drive-side step input model: counts pulses and times the high phase
`timescale 1ns/1ps
`default_nettype none
module pulse_sink (
  input  wire logic clk,
  input  wire logic pin,
  output int        pulses,
  output int        hi_len
);
  int   run = 0;
  logic prev = 1'b0;
  initial pulses = 0;
  initial hi_len = 0;
  // A drive steps on rising edges only; high time is kept in clocks
  always @(posedge clk) begin
    if (pin === 1'b1 && prev !== 1'b1) pulses <= pulses + 1;
    if (pin === 1'b1) run <= run + 1;
    else begin
      if (prev === 1'b1) hi_len <= run;
      run <= 0;
    end
    prev <= pin;
  end
endmodule
`default_nettype wire

//--- pulse_unit_top_tb_top.sv
// Register-level testbench for the two-channel pulse unit
`timescale 1ns/1ps
`default_nettype none
module pulse_unit_top_tb_top;
  import pulse_pkg::*;
  logic        MCLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [10:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [3:0]  AVS_BYTEENABLE;
  logic        PULSE_OUTPUT_ZERO, PULSE_OUTPUT_ONE;
  int          miscompares, n_checks, p0, p1, h0, h1, pb;
  // Two segments: 4 ticks once, then 2 ticks growing by 2 for two pulses
  localparam logic [135:0] PROF = 136'h02_0004_0000_00000001_0002_0002_00000002;
  pulse_unit_top #(.TICK_MS_CYCLES(50)) i_pulse_unit_top (.MCLK(MCLK), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PULSE_OUTPUT_ZERO(PULSE_OUTPUT_ZERO), .PULSE_OUTPUT_ONE(PULSE_OUTPUT_ONE));
  pulse_sink i_pulse_sink_0 (.clk(MCLK), .pin(PULSE_OUTPUT_ZERO), .pulses(p0), .hi_len(h0));
  pulse_sink i_pulse_sink_1 (.clk(MCLK), .pin(PULSE_OUTPUT_ONE), .pulses(p1), .hi_len(h1));
  // ------------------------------------------------------------
  // Bus access and checking
  // ------------------------------------------------------------
  task automatic acc(input logic w, input logic [10:0] a, input logic [31:0] d);
    @(posedge MCLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    do begin
      @(posedge MCLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle(input logic [10:0] base);
    for (int i = 0; i < 200; i++) begin
      acc(1'b0, base + OFF_STATUS, 32'h0);
      if (q[ST_IDLE] === 1'b1) break;
    end
    chk(32'(q[ST_IDLE]), 32'h1);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  // Generous: every train here is at most a few hundred clocks long
  initial begin
    repeat (30000) @(posedge MCLK);
    miscompares++;
    wrap_up;
  end
  initial begin
    {RST, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {1'b1, 45'h0};
    AVS_BYTEENABLE = 4'hf;
    miscompares = 0;
    n_checks = 0;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      acc(1'b0, 11'((c / 4) * 32 + (c % 4) * 4), 32'h0);
      chk(q, 32'h0);
    end
    acc(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h80);
    acc(1'b0, 11'h3fc, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, OFF_IMAGE, 32'h0);
    acc(1'b1, OFF_CYCLE, 32'h4);
    acc(1'b1, OFF_COUNT, 32'h2);
    acc(1'b1, OFF_CTRL, 32'h85);
    // Running, then pending, then a third load that must overflow
    repeat (3) acc(1'b1, OFF_LOAD, 32'h1);
    acc(1'b0, OFF_STATUS, 32'h0);
    chk(32'(q[ST_OVF]), 32'h1);
    wait_idle(11'h000);
    chk(p0, 4);
    chk(h0, 50);
    acc(1'b1, OFF_RUN, 32'h1);
    acc(1'b0, OFF_STATUS, 32'h0);
    chk(q, 32'h80);
    acc(1'b1, CH_STRIDE + OFF_CYCLE, 32'h1);
    acc(1'b1, CH_STRIDE + OFF_COUNT, 32'h0);
    acc(1'b1, CH_STRIDE + OFF_CTRL, 32'h85);
    acc(1'b1, CH_STRIDE + OFF_LOAD, 32'h1);
    wait_idle(CH_STRIDE);
    chk(p1, 1);
    chk(h1, 25);
    for (int i = 0; i < 17; i++) begin
      acc(1'b1, RAM_BASE + 11'(4 * i), 32'(PROF[135 - 8 * i -: 8]));
    end
    acc(1'b1, CH_STRIDE + OFF_CTRL, 32'ha0);
    acc(1'b1, CH_STRIDE + OFF_LOAD, 32'h1);
    acc(1'b0, CH_STRIDE + OFF_SEGMENT, 32'h0);
    chk(q, 32'h1);
    wait_idle(CH_STRIDE);
    acc(1'b0, CH_STRIDE + OFF_SEGMENT, 32'h0);
    chk(q, 32'h2);
    chk(p1, 4);
    chk(h1, 50);
    // A delta of -2 on the second segment drives its cycle to zero
    acc(1'b1, RAM_BASE + 11'h02c, 32'hff);
    acc(1'b1, RAM_BASE + 11'h030, 32'hfe);
    acc(1'b1, CH_STRIDE + OFF_LOAD, 32'h1);
    wait_idle(CH_STRIDE);
    acc(1'b0, CH_STRIDE + OFF_STATUS, 32'h0);
    chk(q, 32'h90);
    chk(p1, 6);
    acc(1'b1, CH_STRIDE + OFF_STATUS, 32'h10);
    acc(1'b1, RAM_BASE, 32'h0);
    acc(1'b1, CH_STRIDE + OFF_LOAD, 32'h1);
    acc(1'b0, CH_STRIDE + OFF_STATUS, 32'h0);
    chk(q, 32'h88);
    // Disable lands while the first segment is still being fetched
    acc(1'b1, RAM_BASE, 32'h2);
    acc(1'b1, CH_STRIDE + OFF_LOAD, 32'h1);
    acc(1'b1, CH_STRIDE + OFF_CTRL, 32'h20);
    acc(1'b1, CH_STRIDE + OFF_LOAD, 32'h1);
    acc(1'b0, CH_STRIDE + OFF_STATUS, 32'h0);
    chk(q, 32'ha8);
    chk(p1, 6);
    acc(1'b1, OFF_CYCLE, 32'h3);
    acc(1'b1, OFF_COUNT, 32'h1);
    acc(1'b1, OFF_LOAD, 32'h1);
    wait_idle(11'h000);
    chk(h0, 50);
    acc(1'b1, OFF_CYCLE, 32'h4);
    acc(1'b1, OFF_WIDTH, 32'h2);
    acc(1'b1, OFF_CTRL, 32'hc3);
    acc(1'b1, OFF_LOAD, 32'h1);
    pb = p0;
    repeat (400) @(posedge MCLK);
    chk(p0 - pb, 4);
    chk(h0, 50);
    // Zero width holds the pin low even with the image bit set
    acc(1'b1, OFF_WIDTH, 32'h0);
    acc(1'b1, OFF_CTRL, 32'hc2);
    acc(1'b1, OFF_LOAD, 32'h1);
    acc(1'b1, OFF_IMAGE, 32'h1);
    pb = p0;
    repeat (200) @(posedge MCLK);
    chk(p0 - pb, 0);
    chk(PULSE_OUTPUT_ZERO, 1'b0);
    acc(1'b1, OFF_CTRL, 32'h0);
    acc(1'b1, OFF_LOAD, 32'h1);
    repeat (3) @(posedge MCLK);
    chk(PULSE_OUTPUT_ZERO, 1'b1);
    acc(1'b1, OFF_IMAGE, 32'h3);
    repeat (3) @(posedge MCLK);
    chk({PULSE_OUTPUT_ONE, PULSE_OUTPUT_ZERO}, 32'h3);
    wrap_up;
  end
endmodule
`default_nettype wire
